// ==== mpr_code_host.sv ====
// processor-side model that presents the voltage code and straps to the regulator
`timescale 1ns/1ps
module mpr_code_host (
  input wire logic mclk_in,
  input wire logic second_mode_in,
  input wire logic table_select_in,
  input wire logic [7:0] want_code_in,
  input wire logic flag_in,
  input wire logic flag_oe_in,
  output logic [7:0] pins_out,
  output logic table_select_out
);
  logic [7:0] code_q;

  // code moves just after an edge and holds until the next request
  always_ff @(posedge mclk_in) begin
    code_q <= want_code_in;
  end

  // second mode: bit6 grounded, bit7 belongs to the device flag with a pull-down
  always_comb begin
    pins_out = code_q;
    table_select_out = table_select_in;
    if (second_mode_in) begin
      pins_out[6] = 1'b0;
      pins_out[7] = flag_oe_in ? flag_in : 1'b0;
      table_select_out = 1'b0;
    end
  end
endmodule

// ==== mpr_config_logic.sv ====
// configuration and supervisory logic of a four-phase step-down controller
//
// Operation
// - strap picks mode and current sense method
// - first mode: table strap picks voltage table
// - first mode: eight code bits set target
// - second mode: code bits 5..0 only
// - second mode: bit7 flags change, 32 ticks
// - first mode: done output after soft-start
// - second mode: power-good needs output in limits
// - overvoltage level per mode or programmed
// - overvoltage latches, low-sides on, fault high
// - preliminary overvoltage active during supply lockout
// - overcurrent gives constant current until undervoltage
// - first mode applies -19mV reference offset
// - code selects divider tap as reference
// - four phases at 150kHz, equally spaced
// - low-side drivers off during soft-start
// - thermal warning and alarm outputs
`timescale 1ns/1ps
`include "mpr_defines.svh"
module mpr_config_logic #(
  parameter int SS_TICKS = `MPR_SS_TICKS,
  parameter int DVID_TICKS = `MPR_DVID_HOLD_TICKS,
  parameter int OSC_PERIOD_CYC = `MPR_OSC_PERIOD_CYC
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire mpr_pkg::mpr_strap_t cfg_strap_in,
  input wire logic table_select_strap_in,
  input wire logic [7:0] voltage_code_pins_in,
  output logic code_transition_flag_out,
  output logic code_transition_flag_oe_out,
  input wire logic enable_in,
  input wire logic supply_ok_in,
  input wire logic [11:0] vout_mv_in,
  input wire logic [11:0] setpoint_mv_in,
  input wire logic ovp_prog_en_in,
  input wire logic [11:0] ovp_prog_mv_in,
  input wire logic [3:0] phase_oc_in,
  input wire logic therm_warn_cmp_in,
  input wire logic therm_alarm_cmp_in,
  output logic startup_done_output_out,
  output logic startup_done_output_oe_out,
  output logic fault_out,
  output logic ls_force_on_out,
  output logic ls_enable_out,
  output logic constant_current_out,
  output logic uv_latched_out,
  output logic second_mode_out,
  output logic ls_sense_out,
  output logic ext_table_out,
  output logic [7:0] tap_select_out,
  output logic signed [7:0] ref_offset_mv_out,
  output logic [11:0] ovp_threshold_mv_out,
  output logic [3:0] phase_tick_out,
  output logic warning_out,
  output logic alarm_out
);
  import mpr_pkg::*;

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------

  // code as seen in each mode; second mode ignores bits 7 and 6
  function automatic logic [7:0] eff_code(input mpr_mode_t m, input logic [7:0] pins);
    eff_code = (m == MPR_MODE_SECOND) ? {2'b00, pins[5:0]} : pins;
  endfunction

  // overvoltage level: programmed, code plus offset, or fixed
  function automatic logic [11:0] ov_level(input mpr_mode_t m, input logic prog_en,
                                           input logic [11:0] prog_mv,
                                           input logic [11:0] sp_mv);
    if (prog_en) begin
      ov_level = prog_mv;
    end else if (m == MPR_MODE_FIRST) begin
      ov_level = 12'(sp_mv + `MPR_OV_OFFSET_MV); // sum wraps above 4095 mV, out of range
    end else begin
      ov_level = `MPR_OV_FIXED_MV;
    end
  endfunction

  // ----------------------------------------------------------------------
  // oscillator
  // ----------------------------------------------------------------------
  mpr_osc_if osc_bus ();

  mpr_phase_osc #(
    .PERIOD_CYC(OSC_PERIOD_CYC)
  ) u_osc (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .osc(osc_bus.osc)
  );

  mpr_cfg_state_t s_q;
  mpr_cfg_state_t s_d;
  logic tick;
  logic ov_cmp;
  logic preov_cmp;
  logic uv_cmp;
  logic [7:0] code_now;
  logic [11:0] ov_thr;

  // phase 0 tick paces soft-start and flag hold counts
  assign tick = osc_bus.tick[0];
  assign osc_bus.run = (s_q.st == MPR_ST_SOFTSTART) || (s_q.st == MPR_ST_RUN);

  // ----------------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------------

  // live code and threshold comparisons
  assign code_now = eff_code(s_q.mode, voltage_code_pins_in);
  assign ov_thr = ov_level(s_q.mode, ovp_prog_en_in, ovp_prog_mv_in, setpoint_mv_in);
  assign ov_cmp = vout_mv_in > ov_thr;
  assign preov_cmp = vout_mv_in > `MPR_PREOV_MV;
  assign uv_cmp = (13'(vout_mv_in) + 13'(`MPR_UV_OFFSET_MV)) < 13'(setpoint_mv_in);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // straps caught once, then frozen until reset
    if (!s_q.captured) begin
      s_d.captured = 1'b1;
      s_d.mode = (cfg_strap_in == MPR_STRAP_SHORT || cfg_strap_in == MPR_STRAP_R170K) ?
                 MPR_MODE_FIRST : MPR_MODE_SECOND;
      s_d.ls_sense = (cfg_strap_in == MPR_STRAP_R170K) || (cfg_strap_in == MPR_STRAP_OPEN);
      s_d.ext_table = (cfg_strap_in == MPR_STRAP_SHORT || cfg_strap_in == MPR_STRAP_R170K) &&
                      !table_select_strap_in;
    end

    // threshold register follows mode, code and programming
    s_d.ovp_mv = ov_thr;

    // sequencer
    case (s_q.st)
      MPR_ST_LOCKOUT: begin
        s_d.ss_cnt = 16'h0_000;
        if (!supply_ok_in && preov_cmp) begin
          s_d.ov = 1'b1;
          s_d.st = MPR_ST_LATCHED;
        end else if (s_q.captured && supply_ok_in && enable_in) begin
          s_d.st = MPR_ST_SOFTSTART;
        end
      end
      MPR_ST_SOFTSTART: begin
        if (ov_cmp) begin
          s_d.ov = 1'b1;
          s_d.st = MPR_ST_LATCHED;
        end else if (!supply_ok_in || !enable_in) begin
          s_d.st = MPR_ST_LOCKOUT;
        end else if (tick) begin
          if (s_q.ss_cnt == 16'(SS_TICKS - 1)) begin
            s_d.st = MPR_ST_RUN;
          end else begin
            s_d.ss_cnt = s_q.ss_cnt + 16'h0_001;
          end
        end
      end
      MPR_ST_RUN: begin
        if (ov_cmp) begin
          s_d.ov = 1'b1;
          s_d.st = MPR_ST_LATCHED;
        end else if (uv_cmp) begin
          s_d.uv = 1'b1;
          s_d.st = MPR_ST_LATCHED;
        end else if (!supply_ok_in || !enable_in) begin
          s_d.st = MPR_ST_LOCKOUT;
        end
      end
      MPR_ST_LATCHED: begin
        s_d.st = MPR_ST_LATCHED;
      end
      default: begin
        s_d.st = MPR_ST_LOCKOUT;
      end
    endcase

    // dynamic code change tracking, flag held after last change
    if (s_q.st == MPR_ST_RUN && code_now != s_q.code) begin
      s_d.dvid = 1'b1;
      s_d.dvid_cnt = 6'h00;
    end else if (s_q.dvid && tick) begin
      if (s_q.dvid_cnt == 6'(DVID_TICKS - 1)) begin
        s_d.dvid = 1'b0;
      end else begin
        s_d.dvid_cnt = s_q.dvid_cnt + 6'h01;
      end
    end
    s_d.code = code_now;

    // constant current while any phase over its limit
    // follows the next state so a latch in this cycle drops constant current
    s_d.cc = (s_d.st == MPR_ST_RUN) && (|phase_oc_in);

    // low-side drivers off until soft-start is over
    s_d.ls_en = (s_d.st == MPR_ST_RUN) || s_d.ov;

    // release of done / power-good output
    s_d.pg_rel = (s_q.st == MPR_ST_RUN) && !s_d.ov && !s_d.uv &&
                 ((s_q.mode == MPR_MODE_FIRST) || (!ov_cmp && !uv_cmp));

    // thermal comparators
    s_d.warn = therm_warn_cmp_in;
    s_d.alarm = therm_alarm_cmp_in;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_q <= '{st: MPR_ST_LOCKOUT, captured: 1'b0, mode: MPR_MODE_FIRST, ls_sense: 1'b0,
               ext_table: 1'b0, code: `MPR_CODE_RESET, dvid: 1'b0, dvid_cnt: 6'h00,
               ss_cnt: 16'h0_000, ov: 1'b0, uv: 1'b0, cc: 1'b0, warn: 1'b0,
               alarm: 1'b0, pg_rel: 1'b0, ls_en: 1'b0, ovp_mv: 12'h0_000};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------

  // bit 7 is only driven as a flag in the second mode
  assign code_transition_flag_out = 1'b1;
  assign code_transition_flag_oe_out = (s_q.mode == MPR_MODE_SECOND) && s_q.dvid;

  // open-drain done output, pulled low until released
  assign startup_done_output_out = 1'b0;
  assign startup_done_output_oe_out = !s_q.pg_rel;

  // protection and configuration status
  assign fault_out = s_q.ov;
  assign ls_force_on_out = s_q.ov;
  assign ls_enable_out = s_q.ls_en;
  assign constant_current_out = s_q.cc;
  assign uv_latched_out = s_q.uv;
  assign second_mode_out = (s_q.mode == MPR_MODE_SECOND);
  assign ls_sense_out = s_q.ls_sense;
  assign ext_table_out = s_q.ext_table;
  assign tap_select_out = s_q.code;
  assign ref_offset_mv_out = (s_q.mode == MPR_MODE_FIRST) ? `MPR_REF_OFFSET_MV : 8'h00;
  assign ovp_threshold_mv_out = s_q.ovp_mv;
  assign phase_tick_out = osc_bus.tick;
  assign warning_out = s_q.warn;
  assign alarm_out = s_q.alarm;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  sequence code_moved_s;
    (s_q.st == MPR_ST_RUN) && (code_now != s_q.code) && (s_q.mode == MPR_MODE_SECOND);
  endsequence

  sequence flag_held_s;
    code_transition_flag_oe_out [*8];
  endsequence

  AST_STRAP_FROZEN: assert property (s_q.captured |=> $stable(s_q.mode) && $stable(s_q.ls_sense))
    else $error("strap settings changed after capture");

  AST_STRAP_DECODE: assert property (!s_q.captured && cfg_strap_in == MPR_STRAP_R270K |=>
                                     second_mode_out && !ls_sense_out)
    else $error("strap decode wrong");

  AST_OV_LATCH: assert property (s_q.st != MPR_ST_LATCHED && s_q.st != MPR_ST_LOCKOUT && ov_cmp
                                 |=> fault_out && ls_force_on_out ##1 fault_out [*4])
    else $error("overvoltage not latched");

  AST_PREOV: assert property (s_q.st == MPR_ST_LOCKOUT && !supply_ok_in && preov_cmp
                              |=> fault_out)
    else $error("preliminary overvoltage missed");

  AST_DVID_FLAG: assert property (code_moved_s |=> flag_held_s)
    else $error("transition flag not held");

  AST_DONE_LOW: assert property ((s_q.ov || s_q.uv) |-> startup_done_output_oe_out)
    else $error("done output released while latched");

  AST_LS_OFF_SS: assert property (s_q.st == MPR_ST_SOFTSTART |-> !ls_enable_out)
    else $error("low-side enabled in soft-start");

  AST_REF_OFFSET: assert property (s_q.captured && !second_mode_out |->
                                   ref_offset_mv_out == -8'sd19)
    else $error("reference offset wrong");

  AST_OV_FIXED: assert property (s_q.captured && second_mode_out && !ovp_prog_en_in
                                 |=> ovp_threshold_mv_out == 12'd1800)
    else $error("fixed overvoltage level wrong");

  AST_UV_LATCH: assert property (s_q.st == MPR_ST_RUN && !ov_cmp && uv_cmp |=>
                                 uv_latched_out && !constant_current_out)
    else $error("undervoltage not latched");

  AST_TAP: assert property (s_q.captured && second_mode_out |=> tap_select_out[7:6] == 2'b00)
    else $error("unused code bits reached tap select");
endmodule

// ==== mpr_defines.svh ====
// timing counts, thresholds and reset values of the regulator supervisory logic
`ifndef MPR_DEFINES_SVH
`define MPR_DEFINES_SVH

// ----------------------------------------------------------------------
// clock and oscillator
// ----------------------------------------------------------------------
`define MPR_CLK_FREQ_KHZ 250000
`define MPR_OSC_FREQ_KHZ 150
`define MPR_OSC_PERIOD_CYC (`MPR_CLK_FREQ_KHZ / `MPR_OSC_FREQ_KHZ)
`define MPR_PHASES 4

// ----------------------------------------------------------------------
// sequencing counts, in oscillator ticks
// ----------------------------------------------------------------------
`define MPR_DVID_HOLD_TICKS 32
`define MPR_SS_TICKS 64

// ----------------------------------------------------------------------
// protection levels and reference offset in millivolts, reset code
// ----------------------------------------------------------------------
`define MPR_OV_OFFSET_MV 12'h0_096
`define MPR_OV_FIXED_MV 12'h0_708
`define MPR_PREOV_MV 12'h0_708
`define MPR_UV_OFFSET_MV 12'h0_2EE
`define MPR_REF_OFFSET_MV 8'hED
`define MPR_CODE_RESET 8'hFF

`endif

// ==== mpr_osc_if.sv ====
// carrier between the sequencer and the phase oscillator
`timescale 1ns/1ps
interface mpr_osc_if;
  logic run;
  logic [3:0] tick;
  modport osc (input run, output tick);
  modport ctl (output run, input tick);
endinterface

// ==== mpr_phase_osc.sv ====
// four-phase oscillator producing equally spaced one-cycle switching ticks
`timescale 1ns/1ps
`include "mpr_defines.svh"
module mpr_phase_osc #(
  parameter int PERIOD_CYC = `MPR_OSC_PERIOD_CYC
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  mpr_osc_if.osc osc
);
  import mpr_pkg::*;

  localparam int CW = $clog2(PERIOD_CYC);

  logic [CW-1:0] cnt_q;
  logic [3:0] tick_q;

  // free-running period counter, ticks spaced a quarter period apart
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= '0;
      tick_q <= 4'h0;
    end else begin
      if (cnt_q == CW'(PERIOD_CYC - 1)) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
      for (int i = 0; i < `MPR_PHASES; i++) begin
        tick_q[i] <= osc.run && (cnt_q == CW'((PERIOD_CYC * i) / `MPR_PHASES));
      end
    end
  end

  assign osc.tick = tick_q;
endmodule

// ==== mpr_pkg.sv ====
// types shared by the regulator supervisory logic
package mpr_pkg;

  // strap level as resolved by the window comparator on the strap pin
  typedef enum logic [1:0] {
    MPR_STRAP_SHORT,
    MPR_STRAP_R170K,
    MPR_STRAP_R270K,
    MPR_STRAP_OPEN
  } mpr_strap_t;

  // processor compatibility mode
  typedef enum logic {
    MPR_MODE_FIRST,
    MPR_MODE_SECOND
  } mpr_mode_t;

  // start-up sequence
  typedef enum logic [1:0] {
    MPR_ST_LOCKOUT,
    MPR_ST_SOFTSTART,
    MPR_ST_RUN,
    MPR_ST_LATCHED
  } mpr_state_t;

  typedef struct packed {
    mpr_state_t st;
    logic captured;
    mpr_mode_t mode;
    logic ls_sense;
    logic ext_table;
    logic [7:0] code;
    logic dvid;
    logic [5:0] dvid_cnt;
    logic [15:0] ss_cnt;
    logic ov;
    logic uv;
    logic cc;
    logic warn;
    logic alarm;
    logic pg_rel;
    logic ls_en;
    logic [11:0] ovp_mv;
  } mpr_cfg_state_t;

endpackage

// ==== tb.sv ====
// self-checking bench of the regulator configuration and supervisory logic
`timescale 1ns/1ps
module tb;
  import mpr_pkg::*;
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end

  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  mpr_strap_t strap = MPR_STRAP_SHORT;
  logic tsel = 1'b1;
  logic enable = 1'b0;
  logic supply_ok = 1'b0;
  logic prog_en = 1'b0;
  logic tw = 1'b0;
  logic ta = 1'b0;
  logic [7:0] want = 8'h00;
  logic [11:0] vout = 12'h000;
  logic [11:0] setp = 12'h4B0;
  logic [11:0] progmv = 12'h000;
  logic [3:0] oc = 4'h0;
  logic flag, flag_oe, done, done_oe, fault, ls_on, ls_en, cc, uv, second, lss, ext;
  logic host_second, tsel_pin, warn, alarm;
  logic [7:0] pins, tap;
  logic [11:0] ovth;
  logic [3:0] tick;
  logic signed [7:0] refo;
  int err_total = 0;
  int n_compared = 0;

  // ----------------------------------------------------------------------
  // clock, partner and design
  // ----------------------------------------------------------------------
  always #2 mclk_in = ~mclk_in;

  assign host_second = (strap == MPR_STRAP_R270K) || (strap == MPR_STRAP_OPEN);

  mpr_code_host u_host (.mclk_in(mclk_in), .second_mode_in(host_second),
    .table_select_in(tsel), .want_code_in(want), .flag_in(flag), .flag_oe_in(flag_oe),
    .pins_out(pins), .table_select_out(tsel_pin));

  mpr_config_logic #(.SS_TICKS(2), .DVID_TICKS(32), .OSC_PERIOD_CYC(8)) u_dut (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .cfg_strap_in(strap),
    .table_select_strap_in(tsel_pin), .voltage_code_pins_in(pins),
    .code_transition_flag_out(flag), .code_transition_flag_oe_out(flag_oe),
    .enable_in(enable), .supply_ok_in(supply_ok), .vout_mv_in(vout), .setpoint_mv_in(setp),
    .ovp_prog_en_in(prog_en), .ovp_prog_mv_in(progmv), .phase_oc_in(oc),
    .therm_warn_cmp_in(tw), .therm_alarm_cmp_in(ta), .startup_done_output_out(done),
    .startup_done_output_oe_out(done_oe), .fault_out(fault), .ls_force_on_out(ls_on),
    .ls_enable_out(ls_en), .constant_current_out(cc), .uv_latched_out(uv),
    .second_mode_out(second), .ls_sense_out(lss), .ext_table_out(ext),
    .tap_select_out(tap), .ref_offset_mv_out(refo), .ovp_threshold_mv_out(ovth),
    .phase_tick_out(tick), .warning_out(warn), .alarm_out(alarm));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // reset held two cycles with straps settled beforehand
  task automatic do_reset(input mpr_strap_t s, input logic ts);
    @(posedge mclk_in);
    arst_n_in <= 1'b0;
    strap <= s;
    tsel <= ts;
    supply_ok <= 1'b0;
    enable <= 1'b0;
    vout <= 12'h4B0;
    repeat (2) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(negedge mclk_in);
  endtask

  // supply and enable up, then soft-start runs to completion
  task automatic start_up();
    int k;
    @(posedge mclk_in);
    supply_ok <= 1'b1;
    enable <= 1'b1;
    repeat (4) @(negedge mclk_in);
    `CHK("ls_off_softstart", 1'b0, ls_en)
    `CHK("done_held", 1'b1, done_oe)
    for (k = 0; k < 100 && done_oe !== 1'b0; k++) @(negedge mclk_in);
    `CHK("done_released", 1'b0, done_oe)
    `CHK("done_level", 1'b0, done)
    `CHK("ls_on_run", 1'b1, ls_en)
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_straps();
    for (int i = 0; i < 4; i++) begin
      do_reset(mpr_strap_t'(i), 1'b1);
      `CHK("second_mode", logic'(i >= 2), second)
      `CHK("ls_sense", logic'(i % 2), lss)
      `CHK("ref_offset", (i < 2) ? 8'hED : 8'h00, refo)
    end
    @(posedge mclk_in);
    strap <= MPR_STRAP_SHORT;
    repeat (3) @(negedge mclk_in);
    `CHK("held_mode", 1'b1, second)
  endtask

  task automatic t_first();
    want <= 8'hA5;
    do_reset(MPR_STRAP_SHORT, 1'b0);
    start_up();
    `CHK("tap_first", 8'hA5, tap)
    `CHK("ext_table", 1'b1, ext)
    `CHK("ovp_default", 12'h546, ovth)
    @(posedge mclk_in);
    want <= 8'h5A;
    prog_en <= 1'b1;
    progmv <= 12'h5DC;
    vout <= 12'h5DC;
    repeat (4) @(negedge mclk_in);
    `CHK("tap_change", 8'h5A, tap)
    `CHK("no_flag_first", 1'b0, flag_oe)
    `CHK("ovp_prog", 12'h5DC, ovth)
    `CHK("no_ov_at_level", 1'b0, fault)
    @(posedge mclk_in);
    vout <= 12'h5DD;
    repeat (2) @(negedge mclk_in);
    `CHK("ov_fault", 1'b1, fault)
    `CHK("ov_ls_on", 1'b1, ls_on)
    @(posedge mclk_in);
    vout <= 12'h4B0;
    prog_en <= 1'b0;
    repeat (5) @(negedge mclk_in);
    `CHK("ov_latched", 1'b1, fault)
    `CHK("done_low_latched", 1'b1, done_oe)
  endtask

  task automatic t_second();
    int k;
    int pos[4];
    want <= 8'hFF;
    do_reset(MPR_STRAP_R270K, 1'b1);
    start_up();
    `CHK("tap_second", 8'h3F, tap)
    `CHK("ovp_fixed", 12'h708, ovth)
    @(posedge mclk_in);
    tw <= 1'b1;
    ta <= 1'b1;
    repeat (2) @(negedge mclk_in);
    `CHK("warning", 1'b1, warn)
    `CHK("alarm", 1'b1, alarm)
    @(posedge mclk_in);
    tw <= 1'b0;
    repeat (2) @(negedge mclk_in);
    `CHK("warning_off", 1'b0, warn)
    pos = '{-1, -1, -1, -1};
    for (int c = 0; c < 16; c++) begin
      @(negedge mclk_in);
      for (int i = 0; i < 4; i++)
        if (tick[i] === 1'b1 && pos[i] < 0) pos[i] = c;
    end
    for (int i = 0; i < 4; i++) `CHK("phase_gap", 2 * i, (pos[i] - pos[0] + 8) % 8)
    @(posedge mclk_in);
    want <= 8'h2A;
    for (k = 0; k < 10 && flag_oe !== 1'b1; k++) @(negedge mclk_in);
    `CHK("flag_rise", 1'b1, flag_oe)
    `CHK("flag_pin", 1'b1, pins[7])
    repeat (200) @(negedge mclk_in);
    @(posedge mclk_in);
    want <= 8'h15;
    repeat (220) @(negedge mclk_in);
    `CHK("flag_restart", 1'b1, flag_oe)
    for (k = 0; k < 80 && flag_oe !== 1'b0; k++) @(negedge mclk_in);
    `CHK("flag_fall", 1'b0, flag_oe)
    `CHK("flag_hold", 1'b1, logic'(k >= 25))
    `CHK("tap_new", 8'h15, tap)
    @(posedge mclk_in);
    oc <= 4'b0100;
    repeat (2) @(negedge mclk_in);
    `CHK("const_current", 1'b1, cc)
    @(posedge mclk_in);
    oc <= 4'h0;
    vout <= 12'h1C2;
    repeat (2) @(negedge mclk_in);
    `CHK("cc_off", 1'b0, cc)
    `CHK("uv_edge", 1'b0, uv)
    @(posedge mclk_in);
    vout <= 12'h1C1;
    repeat (2) @(negedge mclk_in);
    `CHK("uv_trip", 1'b1, uv)
    `CHK("pg_low_uv", 1'b1, done_oe)
  endtask

  task automatic t_pre_ov();
    do_reset(MPR_STRAP_OPEN, 1'b0);
    @(posedge mclk_in);
    vout <= 12'h708;
    repeat (2) @(negedge mclk_in);
    `CHK("pre_ov_edge", 1'b0, fault)
    @(posedge mclk_in);
    vout <= 12'h709;
    repeat (2) @(negedge mclk_in);
    `CHK("pre_ov_trip", 1'b1, fault)
  endtask

  // ----------------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    t_straps();
    t_first();
    t_second();
    t_pre_ov();
    close_out();
  end

  // hang guard, well beyond the several hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_total++;
    close_out();
  end
endmodule
